// ### rtl/ursm_pkg.sv
// ursm_pkg: offsets, field positions, reset values and codes of the serial register block
package ursm_pkg;
	localparam logic [2:0] OFS_DATA   = 3'h0;
	localparam logic [2:0] OFS_IEN    = 3'h1;
	localparam logic [2:0] OFS_QCTL   = 3'h2;
	localparam logic [2:0] OFS_FMT    = 3'h3;
	localparam logic [2:0] OFS_HSO    = 3'h4;
	localparam logic [2:0] OFS_LINK   = 3'h5;
	localparam logic [2:0] OFS_HSI    = 3'h6;
	localparam logic [2:0] OFS_SPARE  = 3'h7;
	localparam logic [7:0] RST_IEN    = 8'h00;
	localparam logic [7:0] RST_QCTL   = 8'h00;
	localparam logic [7:0] RST_FMT    = 8'h00;
	localparam logic [7:0] RST_HSO    = 8'h00;
	localparam logic [7:0] RST_ISRC   = 8'h01;
	localparam logic [7:0] RST_LINK   = 8'h60;
	localparam logic [3:0] RST_HSI_LO = 4'h0;
	localparam logic [7:0] RST_ZERO   = 8'h00;
	localparam int         FMT_DIVSEL = 7;
	localparam int         FMT_BREAK  = 6;
	localparam int         IEN_RX     = 0;
	localparam int         IEN_TX     = 1;
	localparam int         IEN_LINE   = 2;
	localparam int         IEN_MDM    = 3;
	localparam int         QCTL_EN    = 0;
	localparam int         QCTL_RXCLR = 1;
	localparam int         QCTL_TXCLR = 2;
	localparam int         HSO_DTR    = 0;
	localparam int         HSO_RTS    = 1;
	localparam int         HSO_USER_OUTPUT_ONE   = 2;
	localparam int         HSO_USER_OUTPUT_TWO   = 3;
	localparam int         HSO_LOOP   = 4;
	localparam int         LNK_DR     = 0;
	localparam int         LNK_OE     = 1;
	localparam int         LNK_PE     = 2;
	localparam int         LNK_FE     = 3;
	localparam int         LNK_BI     = 4;
	localparam int         LNK_HOLDING_EMPTY_FLAG   = 5;
	localparam int         LNK_TEMT   = 6;
	localparam int         QDEPTH     = 16;
	localparam int         QAW        = 4;
	localparam logic [2:0] ID_LINE    = 3'h6;
	localparam logic [2:0] ID_RX      = 3'h4;
	localparam logic [2:0] ID_TX      = 3'h2;
	localparam logic [2:0] ID_MDM     = 3'h0;
	localparam logic [2:0] ID_NONE    = 3'h1;
endpackage : ursm_pkg

// ### rtl/ursm_queue.sv
// ursm_queue: sixteen-byte queue with registered read data and clear
`timescale 1ns/1ps
module ursm_queue
	import ursm_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       clr,
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	output logic            empty,
	output logic            full
);
	logic [7:0]   mem_q [QDEPTH];
	logic [QAW:0] wp_q;
	logic [QAW:0] rp_q;

	assign empty = (wp_q == rp_q);
	assign full  = (wp_q[QAW] != rp_q[QAW]) && (wp_q[QAW-1:0] == rp_q[QAW-1:0]);

	// storage, zeroed on reset or clear
	always_ff @(posedge clk) begin
		if (rst || clr) begin
			for (int i = 0; i < QDEPTH; i++) mem_q[i] <= RST_ZERO;
		end else if (wr && !full) begin
			mem_q[wp_q[QAW-1:0]] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || clr) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (wr && !full) wp_q <= wp_q + 1'b1;
			if (rd && !empty) rp_q <= rp_q + 1'b1;
		end
	end

	// registered head of queue
	always_ff @(posedge clk) begin
		if (rst || clr) rdata <= RST_ZERO;
		else if (rd && !empty && (rp_q + 1'b1 != wp_q)) rdata <= mem_q[rp_q[QAW-1:0] + 1'b1];
		else if (!empty && !(rd)) rdata <= mem_q[rp_q[QAW-1:0]];
		else if (wr && (empty || (rd && rp_q + 1'b1 == wp_q))) rdata <= wdata;
	end
endmodule : ursm_queue

// ### rtl/ursm_top.sv
// ursm_top: register bank, reset state and interrupt conditions of the serial unit
// ----------------------------------------
// Overview of operation
// - reset zeroes enables, queue, format, handshake
// - reset loads interrupt source with one
// - reset link condition to 0x60
// - reset clears modem change bits only
// - reset: tx mark, irq low, outputs high
// - reset empties both queues to zero
// - line status read clears error interrupt
// - rx buffer read clears data interrupt
// - modem status read clears modem interrupt
// - offset 0: rx read, tx write
// - divisor select maps divisor bytes at 0,1
// - offset 2 write: enable, rx/tx clear
// - enable bits: rx, tx empty, line
// - source bit0 low when pending, id code
// - format: word length, stop count
// - handshake: dtr, rts, user output one
// - link: data ready, overrun, parity
// - modem: cts change, dsr change, ring end
// - irq high on any enabled active source
// - cts status is inverted cts pin
// ----------------------------------------
`timescale 1ns/1ps
module ursm_top
	import ursm_pkg::*;
(
	input  wire logic       MCLK,
	input  wire logic       RST,
	input  wire logic [2:0] ADDR,
	input  wire logic       RD,
	input  wire logic       WR,
	input  wire logic [7:0] DIN,
	output logic      [7:0] DOUT,
	output logic            DOUT_OE,
	input  wire logic       RX_PUSH,
	input  wire logic [7:0] RX_BYTE,
	input  wire logic       RX_OVERRUN,
	input  wire logic       RX_PARITY,
	input  wire logic       RX_FRAMING,
	input  wire logic       RX_BREAK,
	input  wire logic       TX_POP,
	output logic      [7:0] TX_BYTE,
	output logic            TX_AVAIL,
	input  wire logic       TX_SHIFT_IDLE,
	input  wire logic       TX_BIT,
	input  wire logic       CTS_N,
	input  wire logic       DSR_N,
	input  wire logic       RI_N,
	input  wire logic       DCD_N,
	output logic            SERIAL_TX_PIN,
	output logic            IRQ_PIN,
	output logic            RTS_N,
	output logic            DTR_N,
	output logic            USER_OUTPUT_ONE_N,
	output logic            USER_OUTPUT_TWO_N,
	output logic            FIFO_MODE,
	output logic      [15:0] BAUD_DIVISOR
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] ien_q;
	logic [7:0] qctl_q;
	logic [7:0] fmt_q;
	logic [7:0] hso_q;
	logic [7:0] spare_q;
	logic [7:0] div_lo_q;
	logic [7:0] div_hi_q;
	logic [7:0] link_q;
	logic [3:0] hsi_chg_q;
	logic [3:0] pins_q;
	logic       holding_empty_flag_irq_q;
	logic [7:0] isrc;
	logic [7:0] link_rd;
	logic [7:0] hsi_rd;
	logic       divsel;
	logic       rd_rx;
	logic       wr_tx;
	logic       rd_link;
	logic       rd_hsi;
	logic       rd_isrc;
	logic       rxq_clr;
	logic       txq_clr;
	logic [7:0] rxq_data;
	logic       rxq_empty;
	logic       txq_empty;
	logic       txq_full;
	logic [7:0] txq_data;
	logic       line_act;
	logic       rx_act;
	logic       mdm_act;
	logic       irq_any;
	logic [3:0] pins_now;

	assign divsel  = fmt_q[FMT_DIVSEL];
	assign rd_rx   = RD && ADDR == OFS_DATA && !divsel;
	assign wr_tx   = WR && ADDR == OFS_DATA && !divsel;
	assign rd_link = RD && ADDR == OFS_LINK;
	assign rd_hsi  = RD && ADDR == OFS_HSI;
	assign rd_isrc = RD && ADDR == OFS_QCTL;
	assign rxq_clr = WR && ADDR == OFS_QCTL && DIN[QCTL_RXCLR];
	assign txq_clr = WR && ADDR == OFS_QCTL && DIN[QCTL_TXCLR];
	// pins as status: cts, dsr, ri, dcd, complemented
	assign pins_now = {~DCD_N, ~RI_N, ~DSR_N, ~CTS_N};

	// ----------------------------------------
	// queues
	// ----------------------------------------
	ursm_queue u_rxq (
		.clk   (MCLK),
		.rst   (RST),
		.clr   (rxq_clr),
		.wr    (RX_PUSH),
		.wdata (RX_BYTE),
		.rd    (rd_rx),
		.rdata (rxq_data),
		.empty (rxq_empty),
		.full  ()
	);
	ursm_queue u_txq (
		.clk   (MCLK),
		.rst   (RST),
		.clr   (txq_clr),
		.wr    (wr_tx),
		.wdata (DIN),
		.rd    (TX_POP),
		.rdata (txq_data),
		.empty (txq_empty),
		.full  (txq_full)
	);

	// ----------------------------------------
	// writable registers
	// ----------------------------------------
	always_ff @(posedge MCLK) begin
		if (RST) begin
			ien_q  <= RST_IEN;
			qctl_q <= RST_QCTL;
			fmt_q  <= RST_FMT;
			hso_q  <= RST_HSO;
		end else if (WR) begin
			case (ADDR)
				OFS_IEN:  if (!divsel) ien_q <= {4'h0, DIN[3:0]};
				OFS_QCTL: qctl_q <= {DIN[7:3], 2'b00, DIN[QCTL_EN]};
				OFS_FMT:  fmt_q <= DIN;
				OFS_HSO:  hso_q <= {3'h0, DIN[4:0]};
				default: ;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			div_lo_q <= RST_ZERO;
			div_hi_q <= RST_ZERO;
			spare_q  <= RST_ZERO;
		end else if (WR) begin
			if (ADDR == OFS_DATA && divsel) div_lo_q <= DIN;
			if (ADDR == OFS_IEN && divsel) div_hi_q <= DIN;
			if (ADDR == OFS_SPARE) spare_q <= DIN;
		end
	end

	// ----------------------------------------
	// link condition
	// ----------------------------------------
	always_ff @(posedge MCLK) begin
		if (RST) begin
			link_q <= RST_LINK;
		end else begin
			link_q[LNK_DR]   <= !rxq_empty || RX_PUSH;
			link_q[LNK_HOLDING_EMPTY_FLAG] <= txq_empty && !wr_tx;
			link_q[LNK_TEMT] <= txq_empty && !wr_tx && TX_SHIFT_IDLE;
			link_q[7]        <= 1'b0;
			// sticky errors: the set wins over the read clear
			link_q[LNK_OE] <= RX_OVERRUN | (link_q[LNK_OE] & !rd_link);
			link_q[LNK_PE] <= RX_PARITY | (link_q[LNK_PE] & !rd_link);
			link_q[LNK_FE] <= RX_FRAMING | (link_q[LNK_FE] & !rd_link);
			link_q[LNK_BI] <= RX_BREAK | (link_q[LNK_BI] & !rd_link);
		end
	end
	assign link_rd = link_q;

	// ----------------------------------------
	// modem status
	// ----------------------------------------
	always_ff @(posedge MCLK) begin
		if (RST) pins_q <= pins_now;
		else pins_q <= pins_now;
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			hsi_chg_q <= RST_HSI_LO;
		end else begin
			hsi_chg_q[0] <= (pins_now[0] ^ pins_q[0]) | (hsi_chg_q[0] & !rd_hsi);
			hsi_chg_q[1] <= (pins_now[1] ^ pins_q[1]) | (hsi_chg_q[1] & !rd_hsi);
			hsi_chg_q[2] <= (pins_q[2] & !pins_now[2]) | (hsi_chg_q[2] & !rd_hsi);
			hsi_chg_q[3] <= (pins_now[3] ^ pins_q[3]) | (hsi_chg_q[3] & !rd_hsi);
		end
	end
	assign hsi_rd = {pins_now, hsi_chg_q};

	// ----------------------------------------
	// interrupt conditions
	// ----------------------------------------
	assign line_act = ien_q[IEN_LINE] && (link_q[LNK_OE] | link_q[LNK_PE] | link_q[LNK_FE] | link_q[LNK_BI]);
	assign rx_act   = ien_q[IEN_RX] && link_q[LNK_DR];
	assign mdm_act  = ien_q[IEN_MDM] && (hsi_chg_q != 4'h0);

	// tx empty condition: set on empty edge, cleared by write or source read
	always_ff @(posedge MCLK) begin
		if (RST) begin
			holding_empty_flag_irq_q <= 1'b0;
		end else if (wr_tx || (rd_isrc && isrc[3:0] == {1'b0, ID_TX})) begin
			holding_empty_flag_irq_q <= 1'b0;
		end else if (txq_empty && !link_q[LNK_HOLDING_EMPTY_FLAG]) begin
			holding_empty_flag_irq_q <= 1'b1;
		end else if (WR && ADDR == OFS_IEN && !divsel && DIN[IEN_TX] && !ien_q[IEN_TX] && txq_empty) begin
			holding_empty_flag_irq_q <= 1'b1;
		end
	end

	assign irq_any = line_act || rx_act || (ien_q[IEN_TX] && holding_empty_flag_irq_q) || mdm_act;

	// priority encoder of the pending source
	always_comb begin
		isrc = {qctl_q[QCTL_EN] ? 2'b11 : 2'b00, 3'b000, ID_NONE};
		if (line_act) isrc[3:0] = {1'b0, ID_LINE};
		else if (rx_act) isrc[3:0] = {1'b0, ID_RX};
		else if (ien_q[IEN_TX] && holding_empty_flag_irq_q) isrc[3:0] = {1'b0, ID_TX};
		else if (mdm_act) isrc[3:0] = {1'b0, ID_MDM};
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_ff @(posedge MCLK) begin
		if (RST) begin
			DOUT    <= RST_ZERO;
			DOUT_OE <= 1'b0;
		end else begin
			DOUT_OE <= RD;
			case (ADDR)
				OFS_DATA:  DOUT <= divsel ? div_lo_q : rxq_data;
				OFS_IEN:   DOUT <= divsel ? div_hi_q : ien_q;
				OFS_QCTL:  DOUT <= isrc;
				OFS_FMT:   DOUT <= fmt_q;
				OFS_HSO:   DOUT <= hso_q;
				OFS_LINK:  DOUT <= link_rd;
				OFS_HSI:   DOUT <= hsi_rd;
				OFS_SPARE: DOUT <= spare_q;
				default:   DOUT <= RST_ZERO;
			endcase
		end
	end

	// ----------------------------------------
	// pins
	// ----------------------------------------
	always_ff @(posedge MCLK) begin
		if (RST) begin
			SERIAL_TX_PIN     <= 1'b1;
			IRQ_PIN           <= 1'b0;
			RTS_N             <= 1'b1;
			DTR_N             <= 1'b1;
			USER_OUTPUT_ONE_N <= 1'b1;
			USER_OUTPUT_TWO_N <= 1'b1;
		end else begin
			SERIAL_TX_PIN     <= (TX_BIT | hso_q[HSO_LOOP]) & !fmt_q[FMT_BREAK];
			IRQ_PIN           <= irq_any;
			DTR_N             <= !(hso_q[HSO_DTR] & !hso_q[HSO_LOOP]);
			RTS_N             <= !(hso_q[HSO_RTS] & !hso_q[HSO_LOOP]);
			USER_OUTPUT_ONE_N <= !(hso_q[HSO_USER_OUTPUT_ONE] & !hso_q[HSO_LOOP]);
			USER_OUTPUT_TWO_N <= !(hso_q[HSO_USER_OUTPUT_TWO] & !hso_q[HSO_LOOP]);
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			TX_BYTE      <= RST_ZERO;
			TX_AVAIL     <= 1'b0;
			FIFO_MODE    <= 1'b0;
			BAUD_DIVISOR <= 16'h0000;
		end else begin
			TX_BYTE      <= txq_data;
			TX_AVAIL     <= !txq_empty && !TX_POP;
			FIFO_MODE    <= qctl_q[QCTL_EN];
			BAUD_DIVISOR <= {div_hi_q, div_lo_q};
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_RESET_ISRC: assert property (@(posedge MCLK) RST |=> isrc == RST_ISRC)
		else $error("source not one after reset");
	AST_RESET_LINK: assert property (@(posedge MCLK) RST ##1 RST |-> link_q == RST_LINK)
		else $error("link condition wrong in reset");
	AST_RESET_REGS: assert property (@(posedge MCLK) RST |=> ien_q == RST_IEN && fmt_q == RST_FMT && hso_q == RST_HSO)
		else $error("control registers not cleared");
	AST_RESET_PINS: assert property (@(posedge MCLK) RST |=> ##1 (SERIAL_TX_PIN && !IRQ_PIN && RTS_N && DTR_N) || RST)
		else $error("pins not at reset level");
	AST_LINK_CLR: assert property (@(posedge MCLK) disable iff (RST)
		rd_link && !RX_PARITY |=> !link_q[LNK_PE])
		else $error("parity flag survived read");
	AST_MDM_CLR: assert property (@(posedge MCLK) disable iff (RST)
		rd_hsi && pins_now == pins_q |=> hsi_chg_q == 4'h0)
		else $error("modem changes survived read");
	AST_CTS_CHG: assert property (@(posedge MCLK) disable iff (RST)
		$changed(pins_q[0]) && !$past(RST) |-> hsi_chg_q[0])
		else $error("cts change not flagged");
	AST_IRQ: assert property (@(posedge MCLK) disable iff (RST)
		irq_any |=> IRQ_PIN)
		else $error("irq pin missed source");
	AST_PENDING: assert property (@(posedge MCLK) disable iff (RST)
		irq_any |-> !isrc[0])
		else $error("pending bit wrong");
	AST_DIVISOR: assert property (@(posedge MCLK) disable iff (RST)
		WR && ADDR == OFS_DATA && divsel |=> ##1 BAUD_DIVISOR[7:0] == $past(DIN, 2))
		else $error("divisor low not loaded");
	AST_SRC_TX_CLR: assert property (@(posedge MCLK) disable iff (RST)
		rd_isrc && isrc[3:0] == {1'b0, ID_TX} |=> !holding_empty_flag_irq_q)
		else $error("tx empty condition survived source read");
	AST_HOLDING_EMPTY_FLAG_WR: assert property (@(posedge MCLK) disable iff (RST)
		wr_tx |=> !holding_empty_flag_irq_q)
		else $error("tx empty condition survived write");
	AST_TXQ_CLR: assert property (@(posedge MCLK) disable iff (RST)
		txq_clr |=> txq_empty)
		else $error("tx queue not emptied");
	AST_RXQ_CLR: assert property (@(posedge MCLK) disable iff (RST)
		rxq_clr |=> rxq_empty)
		else $error("rx queue not emptied");
	AST_READ_OE: assert property (@(posedge MCLK) disable iff (RST)
		RD |=> DOUT_OE)
		else $error("read data not enabled");
	COV_RX_READ: cover property (@(posedge MCLK) RX_PUSH ##2 rd_rx);
	COV_IRQ: cover property (@(posedge MCLK) !IRQ_PIN ##1 IRQ_PIN);
	COV_DIV: cover property (@(posedge MCLK) WR && ADDR == OFS_DATA && divsel);
	COV_TX_EMPTY: cover property (@(posedge MCLK) holding_empty_flag_irq_q && ien_q[IEN_TX] ##1 rd_isrc);
endmodule : ursm_top

// ### bench/ursm_host.sv
// ursm_host: host cpu model driving the parallel register port
`timescale 1ns/1ps
module ursm_host (
	input  wire logic       mclk,
	output logic      [2:0] addr,
	output logic            rd,
	output logic            wr,
	output logic      [7:0] din,
	input  wire logic [7:0] dout,
	input  wire logic       dout_oe
);
	initial begin
		addr = 3'h0;
		rd   = 1'b0;
		wr   = 1'b0;
		din  = 8'h00;
	end
	// one-cycle write strobe, data lines inverted once released
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(negedge mclk);
		addr = a;
		din  = d;
		wr   = 1'b1;
		@(negedge mclk);
		wr  = 1'b0;
		din = ~d;
	endtask : wr_reg
	// one-cycle read strobe, data taken while the output enable shows
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		int n;
		@(negedge mclk);
		addr = a;
		rd   = 1'b1;
		@(negedge mclk);
		rd = 1'b0;
		n  = 0;
		while (dout_oe !== 1'b1 && n < 3) begin
			@(negedge mclk);
			n++;
		end
		d = dout;
	endtask : rd_reg
endmodule : ursm_host

// ### bench/uart_reset_and_register_map_tb.sv
// uart_reset_and_register_map_tb: register map and reset tests of the serial unit
`timescale 1ns/1ps
module uart_reset_and_register_map_tb;
	import ursm_pkg::*;
	logic        MCLK = 1'b0;
	logic        RST = 1'b1;
	logic [2:0]  ADDR;
	logic [7:0]  DIN, DOUT, TX_BYTE, RX_BYTE = 8'h00;
	logic        RD, WR, DOUT_OE, TX_AVAIL, SERIAL_TX_PIN, IRQ_PIN, FIFO_MODE;
	logic        RTS_N, DTR_N, USER_OUTPUT_ONE_N, USER_OUTPUT_TWO_N;
	logic        RX_PUSH = 1'b0, TX_POP = 1'b0, CTS_N = 1'b1, RI_N = 1'b1, DSR_N = 1'b1;
	logic [3:0]  err = 4'h0;
	logic [15:0] BAUD_DIVISOR;
	int          fail_count = 0, samples_checked = 0;

	always #20 MCLK = ~MCLK;

	ursm_host host (.mclk(MCLK), .addr(ADDR), .rd(RD), .wr(WR), .din(DIN), .dout(DOUT), .dout_oe(DOUT_OE));
	ursm_top dut (
		.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .RD(RD), .WR(WR), .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE),
		.RX_PUSH(RX_PUSH), .RX_BYTE(RX_BYTE), .RX_OVERRUN(err[0]), .RX_PARITY(err[1]), .RX_FRAMING(err[2]),
		.RX_BREAK(err[3]), .TX_POP(TX_POP), .TX_BYTE(TX_BYTE), .TX_AVAIL(TX_AVAIL), .TX_SHIFT_IDLE(1'b1),
		.TX_BIT(1'b1), .CTS_N(CTS_N), .DSR_N(DSR_N), .RI_N(RI_N), .DCD_N(1'b1), .SERIAL_TX_PIN(SERIAL_TX_PIN),
		.IRQ_PIN(IRQ_PIN), .RTS_N(RTS_N), .DTR_N(DTR_N), .USER_OUTPUT_ONE_N(USER_OUTPUT_ONE_N),
		.USER_OUTPUT_TWO_N(USER_OUTPUT_TWO_N), .FIFO_MODE(FIFO_MODE), .BAUD_DIVISOR(BAUD_DIVISOR)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge MCLK);
	endtask : cyc
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic pin(input string nm, input logic e, input logic s);
		chk(nm, {15'h0000, e}, {15'h0000, s});
	endtask : pin
	task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] e);
		logic [7:0] v;
		host.rd_reg(a, v);
		chk(nm, {8'h00, e}, {8'h00, v});
	endtask : rchk
	function automatic logic [15:0] outs();
		return {12'h000, RTS_N, DTR_N, USER_OUTPUT_ONE_N, USER_OUTPUT_TWO_N};
	endfunction : outs
	function automatic logic [7:0] hsi(input logic [3:0] lo);
		return {1'b0, ~RI_N, ~DSR_N, ~CTS_N, lo};
	endfunction : hsi
	task automatic push_rx(input logic [7:0] b);
		@(negedge MCLK);
		RX_BYTE = b;
		RX_PUSH = 1'b1;
		@(negedge MCLK);
		RX_PUSH = 1'b0;
		RX_BYTE = ~b;
	endtask : push_rx
	task automatic pop_tx;
		@(negedge MCLK);
		TX_POP = 1'b1;
		@(negedge MCLK);
		TX_POP = 1'b0;
		cyc(2);
	endtask : pop_tx
	task automatic done(input string t);
		$display("test %s complete", t);
	endtask : done
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	task automatic reset_chk;
		pin("irq", 1'b0, IRQ_PIN);
		pin("serial_tx_pin", 1'b1, SERIAL_TX_PIN);
		chk("outs_n", 16'h000f, outs());
		chk("tx_q", 16'h0000, {7'h00, TX_AVAIL, TX_BYTE});
		pin("fifo", 1'b0, FIFO_MODE);
		rchk("ien", OFS_IEN, RST_IEN);
		rchk("fmt", OFS_FMT, RST_FMT);
		rchk("hso", OFS_HSO, RST_HSO);
		rchk("src", OFS_QCTL, RST_ISRC);
		rchk("link", OFS_LINK, RST_LINK);
		rchk("hsi", OFS_HSI, hsi(RST_HSI_LO));
	endtask : reset_chk

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		cyc(2);
		RST = 1'b0;
		reset_chk();
		done("reset");
		host.wr_reg(OFS_FMT, 8'h07);
		rchk("fmt", OFS_FMT, 8'h07);
		host.wr_reg(OFS_SPARE, 8'ha5);
		rchk("spare", OFS_SPARE, 8'ha5);
		host.wr_reg(OFS_HSO, 8'h07);
		cyc(1);
		chk("outs_on", 16'h0001, outs());
		host.wr_reg(OFS_HSO, 8'h1f);
		cyc(1);
		chk("outs_loop", 16'h000f, outs());
		host.wr_reg(OFS_FMT, 8'h83);
		host.wr_reg(OFS_DATA, 8'h34);
		host.wr_reg(OFS_IEN, 8'h12);
		rchk("div_lo", OFS_DATA, 8'h34);
		rchk("div_hi", OFS_IEN, 8'h12);
		chk("div", 16'h1234, BAUD_DIVISOR);
		host.wr_reg(OFS_FMT, 8'h03);
		rchk("ien_kept", OFS_IEN, 8'h00);
		pin("tx_none", 1'b0, TX_AVAIL);
		done("fields");
		host.wr_reg(OFS_IEN, 8'h01);
		push_rx(8'h5a);
		cyc(2);
		pin("irq_rx", 1'b1, IRQ_PIN);
		rchk("src_rx", OFS_QCTL, {5'h00, ID_RX});
		rchk("link_dr", OFS_LINK, 8'h61);
		rchk("rx", OFS_DATA, 8'h5a);
		rchk("src_rx_off", OFS_QCTL, RST_ISRC);
		pin("irq_rx_off", 1'b0, IRQ_PIN);
		host.wr_reg(OFS_IEN, 8'h04);
		for (int i = 0; i < 4; i++) begin
			@(negedge MCLK) err = 4'h1 << i;
			@(negedge MCLK) err = 4'h0;
			cyc(2);
			pin("irq_line", 1'b1, IRQ_PIN);
			rchk("src_line", OFS_QCTL, {5'h00, ID_LINE});
			rchk("link_err", OFS_LINK, RST_LINK | (8'h02 << i));
			rchk("link_clr", OFS_LINK, RST_LINK);
			pin("irq_line_off", 1'b0, IRQ_PIN);
		end
		done("receive");
		host.wr_reg(OFS_IEN, 8'h08);
		CTS_N = 1'b0;
		cyc(4);
		pin("irq_mdm", 1'b1, IRQ_PIN);
		rchk("src_mdm", OFS_QCTL, {5'h00, ID_MDM});
		rchk("hsi_cts", OFS_HSI, hsi(4'h1));
		rchk("hsi_clr", OFS_HSI, hsi(4'h0));
		pin("irq_mdm_off", 1'b0, IRQ_PIN);
		RI_N = 1'b0;
		cyc(4);
		rchk("hsi_ri", OFS_HSI, hsi(4'h0));
		RI_N = 1'b1;
		cyc(4);
		rchk("hsi_teri", OFS_HSI, hsi(4'h4));
		CTS_N = 1'b1;
		cyc(4);
		rchk("hsi_cts_off", OFS_HSI, hsi(4'h1));
		DSR_N = 1'b0;
		cyc(4);
		rchk("hsi_dsr", OFS_HSI, hsi(4'h2));
		done("modem");
		host.wr_reg(OFS_IEN, 8'h02);
		cyc(2);
		pin("irq_tx", 1'b1, IRQ_PIN);
		rchk("src_tx", OFS_QCTL, {5'h00, ID_TX});
		rchk("src_tx_read", OFS_QCTL, RST_ISRC);
		host.wr_reg(OFS_DATA, 8'h3c);
		cyc(2);
		chk("tx_head", 16'h013c, {7'h00, TX_AVAIL, TX_BYTE});
		pop_tx();
		pin("irq_tx_empty", 1'b1, IRQ_PIN);
		host.wr_reg(OFS_DATA, 8'h11);
		cyc(2);
		pin("irq_tx_wr", 1'b0, IRQ_PIN);
		host.wr_reg(OFS_IEN, 8'h00);
		done("transmit");
		host.wr_reg(OFS_QCTL, 8'h01);
		cyc(1);
		pin("fifo_on", 1'b1, FIFO_MODE);
		rchk("src_fifo", OFS_QCTL, 8'hc1);
		push_rx(8'h77);
		host.wr_reg(OFS_DATA, 8'h66);
		host.wr_reg(OFS_QCTL, 8'h07);
		cyc(2);
		pin("tx_clr", 1'b0, TX_AVAIL);
		pin("fifo_kept", 1'b1, FIFO_MODE);
		rchk("rx_clr", OFS_LINK, RST_LINK);
		host.wr_reg(OFS_LINK, 8'h9f);
		rchk("link_ro", OFS_LINK, RST_LINK);
		done("queue control");
		host.wr_reg(OFS_IEN, 8'h0f);
		host.wr_reg(OFS_HSO, 8'h0f);
		host.wr_reg(OFS_FMT, 8'h43);
		push_rx(8'h99);
		host.wr_reg(OFS_DATA, 8'h55);
		cyc(2);
		pin("brk", 1'b0, SERIAL_TX_PIN);
		RST = 1'b1;
		cyc(2);
		RST = 1'b0;
		reset_chk();
		done("mid reset");
		print_verdict();
	end

	initial begin
		#100000;
		fail_count++;
		print_verdict();
	end
endmodule : uart_reset_and_register_map_tb
